// ==== verification/rf_switch_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// Watches the register port and the switch outputs of the controller
module rf_switch_assertions (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [1:0] i_fault_code,
	input wire logic [7:0] o_rd_data,
	input wire logic o_rd_valid,
	input wire logic [3:0] o_path_close,
	input wire logic o_fault,
	input wire logic o_irq
);
	import rf_switch_pkg::*;
	default clocking @(posedge i_ref_clk); endclocking
	default disable iff (!i_rst_n);
	// Read answers occupy exactly the slot after the strobe
	chk_rd_answer: assert property (i_rd |=> o_rd_valid) else $error("read not answered");
	chk_rd_idle: assert property (!i_rd |=> !o_rd_valid && o_rd_data == 8'h00) else $error("data outside slot");
	chk_rsvd_zero: assert property (o_rd_valid |-> o_rd_data[5:4] == RSVD_VALUE) else $error("reserved not zero");
	chk_path_readback: assert property (i_rd && i_addr == ADDR_SWITCH |=>
		o_rd_data[3:0] == $past(o_path_close)) else $error("enables not read back");
	chk_fault_readback: assert property (i_rd && i_addr == ADDR_SWITCH |=>
		(o_rd_data[7:6] != 2'h0) == $past(o_fault)) else $error("fault field wrong");
	// Enables move only on a write to the switch register
	chk_path_write: assert property (i_wr && i_addr == ADDR_SWITCH |=>
		o_path_close == $past(i_wr_data[3:0])) else $error("enables not written");
	chk_path_hold: assert property (!(i_wr && i_addr == ADDR_SWITCH) |=> $stable(o_path_close))
		else $error("enables moved");
	chk_fault_level: assert property (o_fault == ($past(i_fault_code) != 2'h0)) else $error("fault flag wrong");
	chk_unmapped_zero: assert property (i_rd && i_addr != ADDR_SWITCH && i_addr != ADDR_IRQ_STATUS
		&& i_addr != ADDR_IRQ_MASK |=> o_rd_data == 8'h00) else $error("unmapped read not zero");
	// With every status bit masked off the line must drop in the next cycle
	chk_irq_masked: assert property (i_wr && i_addr == ADDR_IRQ_MASK && i_wr_data[3:0] == 4'h0 |=> !o_irq)
		else $error("irq high while all masked");
	cover property (i_wr && i_addr == ADDR_SWITCH && i_wr_data[5:4] != 2'h0);
	cover property (o_irq);
	cover property (o_fault && i_rd);
endmodule
bind rf_switch_ctrl rf_switch_assertions i_chk (.i_ref_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd,
	.i_fault_code, .o_rd_data, .o_rd_valid, .o_path_close, .o_fault, .o_irq);
`default_nettype wire

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import rf_switch_pkg::*;
	logic i_ref_clk = 1'b0;
	logic i_rst_n = 1'b0;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wr_data = 8'h00;
	logic [1:0] i_fault_code = 2'h0;
	logic [7:0] o_rd_data;
	logic o_rd_valid;
	logic [3:0] o_path_close;
	logic o_fault;
	logic o_irq;
	int errors = 0;
	int n_checks = 0;
	rf_switch_ctrl i_dut (.i_ref_clk, .i_rst_n, .i_addr, .i_wr_data, .i_wr, .i_rd, .i_fault_code,
		.o_rd_data, .o_rd_valid, .o_path_close, .o_fault, .o_irq);
	// 125 MHz reference clock
	initial forever #4 i_ref_clk = ~i_ref_clk;
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	// One-cycle strobes; the #1 lets the answering edge settle before sampling
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wr_data <= d; // Callers keep bits 5:4 zero except the one misuse
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		check(o_rd_data, exp);
		check({7'h00, o_rd_valid}, 8'h01);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence: reset, each path, read-only fields, fault codes, interrupts
	initial begin
		repeat (8) @(posedge i_ref_clk);
		i_rst_n <= 1'b1;
		repeat (3) @(posedge i_ref_clk);
		rd(ADDR_SWITCH, SWITCH_RESET);
		check({4'h0, o_path_close}, 8'h00);
		$display("reset test done");
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_SWITCH, 8'h01 << i);
			check({4'h0, o_path_close}, 8'h01 << i);
			rd(ADDR_SWITCH, 8'h01 << i);
		end
		wr(ADDR_SWITCH, 8'hff); // Deliberate misuse raises the reserved-write flag
		rd(ADDR_SWITCH, 8'h0f);
		wr(8'h30, 8'h00);
		rd(8'h30, 8'h00);
		check({4'h0, o_path_close}, 8'h0f);
		$display("path test done");
		for (int c = 1; c < 5; c++) begin
			@(posedge i_ref_clk);
			i_fault_code <= c[1:0];
			repeat (2) @(posedge i_ref_clk);
			rd(ADDR_SWITCH, {c[1:0], 6'h0f});
			check({7'h00, o_fault}, {7'h00, c[1:0] != 2'h0});
		end
		$display("fault test done");
		// All four events have fired; masked off, the line must stay low
		check({7'h00, o_irq}, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h0f);
		wr(ADDR_IRQ_MASK, 8'h04);
		check({7'h00, o_irq}, 8'h01);
		rd(ADDR_IRQ_MASK, 8'h04);
		wr(ADDR_IRQ_STATUS, 8'h04);
		check({7'h00, o_irq}, 8'h00);
		rd(ADDR_IRQ_STATUS, 8'h0b);
		// Fault-appeared bit is still set; unmask it alone, then mask everything
		wr(ADDR_IRQ_MASK, 8'h01);
		check({7'h00, o_irq}, 8'h01);
		wr(ADDR_IRQ_MASK, 8'h00);
		check({7'h00, o_irq}, 8'h00);
		$display("irq test done");
		finish_test();
	end
endmodule
`default_nettype wire

// ==== verilog/irq_hub.sv ====
`timescale 1ns/1ps
`default_nettype none
module irq_hub (
	input wire logic i_clk,
	input wire logic i_rst_n,
	irq_if.hub bus
);
	import rf_switch_pkg::*;

	typedef struct packed {
		logic [IRQ_W-1:0] status;
		logic [IRQ_W-1:0] mask;
		logic irq;
	} hub_state_t;

	hub_state_t state;
	hub_state_t next_state;

	// Sticky status: a new event outweighs a write-one clear in the same cycle
	always_comb begin
		next_state = state;
		if (bus.wr_status) begin
			next_state.status = state.status & ~bus.wr_data;
		end
		next_state.status = next_state.status | bus.event_set;
		if (bus.wr_mask) begin
			next_state.mask = bus.wr_data;
		end
		// Output registered so the pin never glitches on a decode
		next_state.irq = |(next_state.status & next_state.mask);
	end

	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state <= '{status: IRQ_RESET, mask: IRQ_RESET, irq: 1'h0};
		end else begin
			state <= next_state;
		end
	end

	assign bus.status = state.status;
	assign bus.mask = state.mask;
	assign bus.irq = state.irq;
endmodule
`default_nettype wire

// ==== verilog/irq_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface irq_if #(
	parameter int W = 4
);
	logic [W-1:0] event_set;
	logic wr_status;
	logic wr_mask;
	logic [W-1:0] wr_data;
	logic [W-1:0] status;
	logic [W-1:0] mask;
	logic irq;
	modport hub (
		input event_set,
		input wr_status,
		input wr_mask,
		input wr_data,
		output status,
		output mask,
		output irq
	);
	modport core (
		output event_set,
		output wr_status,
		output wr_mask,
		output wr_data,
		input status,
		input mask,
		input irq
	);
endinterface
`default_nettype wire

// ==== verilog/rf_switch_ctrl.sv ====
// Added by the designer: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module rf_switch_ctrl (
	input wire logic i_ref_clk,
	input wire logic i_rst_n,
	input wire logic [rf_switch_pkg::ADDR_W-1:0] i_addr,
	input wire logic [rf_switch_pkg::DATA_W-1:0] i_wr_data,
	input wire logic i_wr,
	input wire logic i_rd,
	input wire logic [1:0] i_fault_code,
	output logic [rf_switch_pkg::DATA_W-1:0] o_rd_data,
	output logic o_rd_valid,
	output logic [rf_switch_pkg::PATH_N-1:0] o_path_close,
	output logic o_fault,
	output logic o_irq
);
	import rf_switch_pkg::*;

	typedef struct packed {
		logic [PATH_N-1:0] path;
		logic [1:0] fault;
		logic [DATA_W-1:0] rd_data;
		logic rd_valid;
		logic fault_flag;
	} ctrl_state_t;

	// Which register a strobe selects; at most one of sw, status and mask is ever high, and mapped is set with it
	typedef struct packed {
		logic sw;
		logic status;
		logic mask;
		logic mapped;
	} reg_hit_t;

	logic [1:0] rst_sync;
	logic rst_n;
	ctrl_state_t state;
	ctrl_state_t next_state;
	logic wr_switch;
	logic [IRQ_W-1:0] events;
	reg_hit_t wr_hit;
	reg_hit_t rd_hit;
	logic [PATH_N-1:0] wr_path;
	logic wr_rsvd_dirty;
	logic fault_now;
	logic fault_was;
	logic [DATA_W-1:0] rd_word;

	irq_if #(.W(IRQ_W)) irq_bus ();

	// Packs the visible switch register; reserved field always reads zero
	function automatic logic [DATA_W-1:0] pack_switch(
		input logic [PATH_N-1:0] path,
		input logic [1:0] fault
	);
		logic [DATA_W-1:0] v;
		v = SWITCH_RESET;
		v[FAULT_MSB:FAULT_LSB] = fault;
		v[RSVD_MSB:RSVD_LSB] = RSVD_VALUE;
		v[PATH4_BIT] = path[3];
		v[PATH3_BIT] = path[2];
		v[PATH2_BIT] = path[1];
		v[PATH1_BIT] = path[0];
		return v;
	endfunction

	// Widens an interrupt-sized field into the low bits of a read word
	function automatic logic [DATA_W-1:0] widen_irq(input logic [IRQ_W-1:0] v);
		logic [DATA_W-1:0] w;
		w = READ_ZERO;
		w[IRQ_W-1:0] = v;
		return w;
	endfunction

	// Address decode shared by the write side and the read side
	function automatic reg_hit_t decode_addr(input logic [ADDR_W-1:0] a);
		reg_hit_t h;
		h = '0;
		case (a)
			ADDR_SWITCH: begin
				h.sw = 1'h1;
			end
			ADDR_IRQ_STATUS: begin
				h.status = 1'h1;
			end
			ADDR_IRQ_MASK: begin
				h.mask = 1'h1;
			end
			default: begin
				h = '0; // Unmapped offsets select nothing
			end
		endcase
		h.mapped = h.sw | h.status | h.mask;
		return h;
	endfunction

	// Any nonzero code is a detected fault; the code itself is kept for reads
	function automatic logic fault_present(input logic [1:0] code);
		return code != FAULT_NONE;
	endfunction

	// Pulls the four enables out of a write word by their field positions
	function automatic logic [PATH_N-1:0] path_from_word(input logic [DATA_W-1:0] d);
		logic [PATH_N-1:0] p;
		p = PATH_RESET;
		p[3] = d[PATH4_BIT];
		p[2] = d[PATH3_BIT];
		p[1] = d[PATH2_BIT];
		p[0] = d[PATH1_BIT];
		return p;
	endfunction

	// Nonzero reserved bits in a write word; they are dropped, never stored
	function automatic logic rsvd_dirty(input logic [DATA_W-1:0] d);
		return d[RSVD_MSB:RSVD_LSB] != RSVD_VALUE;
	endfunction

	// Read word for one decoded register; an unmapped offset reads zero
	function automatic logic [DATA_W-1:0] read_word(
		input reg_hit_t h,
		input logic [PATH_N-1:0] path,
		input logic [1:0] fault,
		input logic [IRQ_W-1:0] status,
		input logic [IRQ_W-1:0] mask
	);
		logic [DATA_W-1:0] r;
		r = READ_ZERO;
		if (h.sw) begin
			r = pack_switch(path, fault);
		end else if (h.status) begin
			r = widen_irq(status);
		end else if (h.mask) begin
			r = widen_irq(mask);
		end
		return r;
	endfunction

	// Reset release passes two flops so every block leaves reset together
	always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_sync <= RST_SYNC_RESET;
		end else begin
			rst_sync <= {rst_sync[0], 1'h1};
		end
	end
	assign rst_n = rst_sync[1];

	// Decodes are gated by their strobe so an idle bus selects nothing
	always_comb begin
		wr_hit = '0;
		rd_hit = '0;
		if (i_wr) begin
			wr_hit = decode_addr(i_addr);
		end
		if (i_rd) begin
			rd_hit = decode_addr(i_addr);
		end
	end

	// Single fixed address; any other offset is not the switch register
	assign wr_switch = wr_hit.sw;

	// Write-word and detector views used by the events; fault_now also feeds the next state
	assign wr_path = path_from_word(i_wr_data);
	assign wr_rsvd_dirty = rsvd_dirty(i_wr_data);
	assign fault_now = fault_present(i_fault_code);
	assign fault_was = fault_present(state.fault);

	// Events for the interrupt status register
	always_comb begin
		events = IRQ_RESET;
		events[IRQ_FAULT_SET] = !fault_was && fault_now;
		events[IRQ_FAULT_CLEAR] = fault_was && !fault_now;
		// Software must write zero here; flag it so a driver bug is visible
		events[IRQ_RSVD_WRITE] = wr_switch && wr_rsvd_dirty;
		events[IRQ_PATH_CHANGE] = wr_switch && (wr_path != state.path);
	end

	assign irq_bus.event_set = events;
	assign irq_bus.wr_status = wr_hit.status;
	assign irq_bus.wr_mask = wr_hit.mask;

	// Read word picked from the decoded register, registered in the next state
	assign rd_word = read_word(rd_hit, state.path, state.fault, irq_bus.status, irq_bus.mask);
	assign irq_bus.wr_data = i_wr_data[IRQ_W-1:0];

	irq_hub u_irq_hub (
		.i_clk(i_ref_clk),
		.i_rst_n(rst_n),
		.bus(irq_bus)
	);

	// Next state: enables from writes, fault code from the detector, read port
	always_comb begin
		next_state = state;
		// Only the four enables take write data; bits 7:4 of the write are dropped
		if (wr_switch) begin
			next_state.path[3] = i_wr_data[PATH4_BIT];
			next_state.path[2] = i_wr_data[PATH3_BIT];
			next_state.path[1] = i_wr_data[PATH2_BIT];
			next_state.path[0] = i_wr_data[PATH1_BIT];
		end
		// Fault field follows the detector; no software path can write it
		next_state.fault = i_fault_code;
		next_state.fault_flag = fault_now;
		// Read data stands for exactly one cycle after the strobe
		next_state.rd_valid = i_rd;
		next_state.rd_data = READ_ZERO;
		// Unmapped reads keep the zero word but still raise the valid flag
		if (rd_hit.mapped) begin
			next_state.rd_data = rd_word;
		end
	end

	// All paths open and no fault shown after reset
	always_ff @(posedge i_ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= '{path: PATH_RESET, fault: FAULT_NONE, rd_data: READ_ZERO,
				rd_valid: 1'h0, fault_flag: 1'h0};
		end else begin
			state <= next_state;
		end
	end

	assign o_path_close = state.path;
	assign o_fault = state.fault_flag;
	assign o_rd_data = state.rd_data;
	assign o_rd_valid = state.rd_valid;
	assign o_irq = irq_bus.irq;
endmodule
`default_nettype wire

// ==== verilog/rf_switch_pkg.sv ====
`default_nettype none
package rf_switch_pkg;
	// Register port geometry
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	// Register offsets
	localparam logic [7:0] ADDR_SWITCH = 8'h20;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'h21;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h22;
	// Switch control and status field layout
	localparam int FAULT_MSB = 7;
	localparam int FAULT_LSB = 6;
	localparam int RSVD_MSB = 5;
	localparam int RSVD_LSB = 4;
	localparam int PATH4_BIT = 3;
	localparam int PATH3_BIT = 2;
	localparam int PATH2_BIT = 1;
	localparam int PATH1_BIT = 0;
	localparam int PATH_N = 4;
	// Values after reset and fixed codes
	localparam logic [7:0] SWITCH_RESET = 8'h00;
	localparam logic [3:0] PATH_RESET = 4'h0;
	localparam logic [1:0] FAULT_NONE = 2'h0;
	localparam logic [1:0] RSVD_VALUE = 2'h0;
	localparam logic [7:0] READ_ZERO = 8'h00;
	// Interrupt event bits
	localparam int IRQ_W = 4;
	localparam int IRQ_FAULT_SET = 0;
	localparam int IRQ_FAULT_CLEAR = 1;
	localparam int IRQ_RSVD_WRITE = 2;
	localparam int IRQ_PATH_CHANGE = 3;
	localparam logic [3:0] IRQ_RESET = 4'h0;
	// Reset synchroniser reset value
	localparam logic [1:0] RST_SYNC_RESET = 2'h0;
endpackage
`default_nettype wire
